// >>> bio_board.sv
`timescale 1ns/10ps
module bio_board
	import bio_pkg::*;
(
	// Clock
	input  wire logic       ref_clk_in,
	// Port side
	input  wire logic [7:0] pin_out_in,
	input  wire logic [7:0] oe_in,
	input  wire logic [7:0] pullup_in,
	// Switches
	input  wire logic [7:0] sw_en_in,
	input  wire logic [7:0] sw_val_in,
	output logic      [7:0] pin_in_out
);
	logic [7:0] float_q = 8'h00;

	// Undriven lines wander every cycle
	always @(posedge ref_clk_in) begin
		float_q <= ~float_q;
	end

	// Port drive wins, then switch, then pull-up
	assign pin_in_out = (oe_in & pin_out_in) | (~oe_in & sw_en_in & sw_val_in)
		| (~oe_in & ~sw_en_in & (pullup_in | float_q));
endmodule : bio_board

// >>> bio_pkg.sv
package bio_pkg;
	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [2:0] BIO_PORT_A_DATA       = 3'h0;
	localparam logic [2:0] BIO_PORT_A_DIRECTION  = 3'h1;
	localparam logic [2:0] BIO_PORT_A_PULLUP     = 3'h2;
	localparam logic [2:0] BIO_PORT_A_WAKE       = 3'h3;
	localparam logic [2:0] BIO_PORT_B_DATA       = 3'h4;
	localparam logic [2:0] BIO_PORT_B_DIRECTION  = 3'h5;
	localparam logic [2:0] BIO_PORT_B_PULLUP     = 3'h6;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] BIO_DATA_RST          = 8'hFF;
	localparam logic [7:0] BIO_DIR_RST           = 8'hFF;
	localparam logic [7:0] BIO_PULLUP_RST        = 8'h00;
	localparam logic [7:0] BIO_WAKE_RST          = 8'h00;
	localparam logic [7:0] BIO_READ_IDLE         = 8'h00;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} bio_bus_s;
endpackage : bio_pkg

// >>> bio_port.sv
`timescale 1ns/10ps
module bio_port
	import bio_pkg::*;
#(
	parameter int  WIDTH = 8,
	parameter logic [7:0] IMPL = 8'hFF
) (
	// Clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       resetn_in,
	// Register writes
	input  wire logic       data_wr_in,
	input  wire logic       dir_wr_in,
	input  wire logic       pu_wr_in,
	input  wire logic [7:0] wdata_in,
	// Pin side
	input  wire logic [7:0] pin_sync_in,
	input  wire logic [7:0] nmos_in,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe_out,
	output logic      [7:0] pullup_out,
	// Register views
	output logic      [7:0] data_q_out,
	output logic      [7:0] dir_q_out,
	output logic      [7:0] pu_q_out,
	output logic      [7:0] data_rd_out
);
	logic [7:0] data_q;
	logic [7:0] dir_q;
	logic [7:0] pu_q;

	// ****************************************
	// Latches
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			data_q <= BIO_DATA_RST & IMPL;
			dir_q  <= BIO_DIR_RST & IMPL;
			pu_q   <= BIO_PULLUP_RST;
		end else begin
			if (data_wr_in)
				data_q <= wdata_in & IMPL;
			if (dir_wr_in)
				dir_q <= wdata_in & IMPL;
			if (pu_wr_in)
				pu_q <= wdata_in & IMPL;
		end
	end

	// ****************************************
	// Pin drive and readback
	// ****************************************
	assign pin_out     = data_q;
	assign pin_oe_out  = ~dir_q & IMPL;
	assign pullup_out  = pu_q & (dir_q | nmos_in) & IMPL;
	assign data_rd_out = ((dir_q & pin_sync_in) |
	                     (~dir_q & data_q)) & IMPL;
	assign data_q_out  = data_q;
	assign dir_q_out   = dir_q;
	assign pu_q_out    = pu_q;

	AST_OUT_LATCH: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		!data_wr_in |=> data_q == $past(data_q))
		else $error("data latch changed without a write");
	AST_OE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		dir_wr_in |=> pin_oe_out == (~$past(wdata_in) & IMPL))
		else $error("output enable does not follow direction");
	AST_PU: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(pullup_out & ~(dir_q | nmos_in)) == 8'h00)
		else $error("pull-up on while pin is cmos output");
	AST_PU_WR: assert property (@(posedge ref_clk_in)
		disable iff (!resetn_in)
		pu_wr_in |=> ((pullup_out ^ $past(wdata_in)) & dir_q & IMPL) == 8'h00)
		else $error("pull-up does not follow its enable bit");
endmodule : bio_port

// >>> bio_sync.sv
`timescale 1ns/10ps
module bio_sync
	import bio_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             resetn_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : bio_sync

// >>> bio_top.sv
`timescale 1ns/10ps
module bio_top
	import bio_pkg::*;
#(
	parameter logic [7:0] PA_IMPL = 8'hFF,
	parameter logic [7:0] PB_IMPL = 8'h3F
) (
	// Clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       resetn_in,
	// Core data memory access
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [2:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	// Core state
	input  wire logic       halt_mode_in,
	input  wire logic [7:0] pa_gpio_sel_in,
	input  wire logic [7:0] pa_nmos_in,
	input  wire logic [7:0] pb_nmos_in,
	output logic            wake_req_out,
	// Port A pins
	input  wire logic [7:0] pa_pin_in,
	output logic      [7:0] pa_pin_out,
	output logic      [7:0] pa_pin_oe_out,
	output logic      [7:0] pa_pullup_out,
	// Port B pins
	input  wire logic [7:0] pb_pin_in,
	output logic      [7:0] pb_pin_out,
	output logic      [7:0] pb_pin_oe_out,
	output logic      [7:0] pb_pullup_out
);
	bio_bus_s   bus;
	logic [7:0] pa_sync, pb_sync, pa_prev_q;
	logic [7:0] pa_data, pa_dir, pa_pu, pa_rd;
	logic [7:0] pb_data, pb_dir, pb_pu, pb_rd;
	logic [7:0] wake_q, rdata_q, rsel, fall;
	logic       wake_req_q;

	assign bus = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in,
	               wdata: reg_wdata_in};

	function automatic logic hit(input bio_bus_s b, input logic [2:0] a);
		hit = b.wr && (b.addr == a);
	endfunction : hit

	// ****************************************
	// Pin synchronisers
	// ****************************************
	bio_sync #(.WIDTH(8)) u_sync_a (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.async_in   (pa_pin_in),
		.sync_out   (pa_sync)
	);
	bio_sync #(.WIDTH(8)) u_sync_b (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.async_in   (pb_pin_in),
		.sync_out   (pb_sync)
	);

	// ****************************************
	// Ports
	// ****************************************
	bio_port #(.WIDTH(8), .IMPL(PA_IMPL)) u_port_a (
		.ref_clk_in  (ref_clk_in),
		.resetn_in   (resetn_in),
		.data_wr_in  (hit(bus, BIO_PORT_A_DATA)),
		.dir_wr_in   (hit(bus, BIO_PORT_A_DIRECTION)),
		.pu_wr_in    (hit(bus, BIO_PORT_A_PULLUP)),
		.wdata_in    (bus.wdata),
		.pin_sync_in (pa_sync),
		.nmos_in     (pa_nmos_in),
		.pin_out     (pa_pin_out),
		.pin_oe_out  (pa_pin_oe_out),
		.pullup_out  (pa_pullup_out),
		.data_q_out  (pa_data),
		.dir_q_out   (pa_dir),
		.pu_q_out    (pa_pu),
		.data_rd_out (pa_rd)
	);
	bio_port #(.WIDTH(8), .IMPL(PB_IMPL)) u_port_b (
		.ref_clk_in  (ref_clk_in),
		.resetn_in   (resetn_in),
		.data_wr_in  (hit(bus, BIO_PORT_B_DATA)),
		.dir_wr_in   (hit(bus, BIO_PORT_B_DIRECTION)),
		.pu_wr_in    (hit(bus, BIO_PORT_B_PULLUP)),
		.wdata_in    (bus.wdata),
		.pin_sync_in (pb_sync),
		.nmos_in     (pb_nmos_in),
		.pin_out     (pb_pin_out),
		.pin_oe_out  (pb_pin_oe_out),
		.pullup_out  (pb_pullup_out),
		.data_q_out  (pb_data),
		.dir_q_out   (pb_dir),
		.pu_q_out    (pb_pu),
		.data_rd_out (pb_rd)
	);

	// ****************************************
	// Wake enable and wake-up detect
	// ****************************************
	assign fall = pa_prev_q & ~pa_sync & wake_q & pa_gpio_sel_in;

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wake_q     <= BIO_WAKE_RST;
			pa_prev_q  <= 8'h00;
			wake_req_q <= 1'b0;
		end else begin
			if (hit(bus, BIO_PORT_A_WAKE))
				wake_q <= bus.wdata & PA_IMPL;
			pa_prev_q  <= pa_sync;
			wake_req_q <= halt_mode_in && (fall != 8'h00);
		end
	end
	assign wake_req_out = wake_req_q;

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		case (bus.addr)
			BIO_PORT_A_DATA:      rsel = pa_rd;
			BIO_PORT_A_DIRECTION: rsel = pa_dir;
			BIO_PORT_A_PULLUP:    rsel = pa_pu;
			BIO_PORT_A_WAKE:      rsel = wake_q;
			BIO_PORT_B_DATA:      rsel = pb_rd;
			BIO_PORT_B_DIRECTION: rsel = pb_dir;
			BIO_PORT_B_PULLUP:    rsel = pb_pu;
			default:              rsel = BIO_READ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			rdata_q <= BIO_READ_IDLE;
		else if (bus.rd)
			rdata_q <= rsel;
	end
	assign reg_rdata_out = rdata_q;

	// ****************************************
	// Checks
	// ****************************************
	AST_WAKE_ONLY_HALT: assert property (@(posedge ref_clk_in)
		disable iff (!resetn_in)
		!$past(halt_mode_in) |-> !wake_req_out)
		else $error("wake request outside halt");
	AST_WAKE_FALL: assert property (@(posedge ref_clk_in)
		disable iff (!resetn_in)
		(halt_mode_in && (fall != 8'h00)) |=> wake_req_out)
		else $error("missed wake falling edge");
	AST_WAKE_DIS: assert property (@(posedge ref_clk_in)
		disable iff (!resetn_in)
		(wake_q == 8'h00) |=> !wake_req_out)
		else $error("wake without enable");
	AST_RD_UNIMPL: assert property (@(posedge ref_clk_in)
		disable iff (!resetn_in)
		bus.rd && bus.addr == BIO_PORT_B_DATA
		|=> (reg_rdata_out & ~PB_IMPL) == 8'h00)
		else $error("unimplemented bit read nonzero");
	AST_RD_INPUT: assert property (@(posedge ref_clk_in)
		disable iff (!resetn_in)
		bus.rd && bus.addr == BIO_PORT_A_DATA
		|=> reg_rdata_out == $past(((pa_dir & pa_sync) |
		    (~pa_dir & pa_data)) & PA_IMPL))
		else $error("port A readback wrong");
	AST_DIR_RST: assert property (@(posedge ref_clk_in)
		$rose(resetn_in) |-> pa_dir == PA_IMPL)
		else $error("direction not input after reset");

	COV_WAKE: cover property (@(posedge ref_clk_in) wake_req_out);
	COV_OUT: cover property (@(posedge ref_clk_in) pa_pin_oe_out != 8'h00);
	COV_PU: cover property (@(posedge ref_clk_in) pb_pullup_out != 8'h00);
endmodule : bio_top

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top
	import bio_pkg::*;
;
	logic       ref_clk_in, resetn_in, reg_wr_in, reg_rd_in;
	logic       halt_mode_in, wake_req_out, rd_seen;
	logic [2:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out, pa_gpio_sel_in;
	logic [7:0] pa_nmos_in, pb_nmos_in, sw_a, sw_b, sw_en_b;
	logic [7:0] pa_pin_in, pa_pin_out, pa_pin_oe_out, pa_pullup_out;
	logic [7:0] pb_pin_in, pb_pin_out, pb_pin_oe_out, pb_pullup_out;
	logic [7:0] v [8];
	logic [7:0] e [8];
	logic [7:0] exp_q [$];
	int         fails, n_tests, wake_cnt;

	bio_top #(.PA_IMPL(8'hFF), .PB_IMPL(8'h3F)) u_bio_top (
		.ref_clk_in, .resetn_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
		.reg_wdata_in, .reg_rdata_out, .halt_mode_in, .pa_gpio_sel_in,
		.pa_nmos_in, .pb_nmos_in, .wake_req_out, .pa_pin_in, .pa_pin_out,
		.pa_pin_oe_out, .pa_pullup_out, .pb_pin_in, .pb_pin_out,
		.pb_pin_oe_out, .pb_pullup_out);
	bio_board u_board_a (.ref_clk_in, .pin_out_in(pa_pin_out),
		.oe_in(pa_pin_oe_out), .pullup_in(pa_pullup_out),
		.sw_en_in(8'hFF), .sw_val_in(sw_a), .pin_in_out(pa_pin_in));
	bio_board u_board_b (.ref_clk_in, .pin_out_in(pb_pin_out),
		.oe_in(pb_pin_oe_out), .pullup_in(pb_pullup_out),
		.sw_en_in(sw_en_b), .sw_val_in(sw_b), .pin_in_out(pb_pin_in));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
	endtask : rd_reg

	task automatic wake_try(input int b, input logic [7:0] x);
		int c;
		sw_a[b] <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		c = wake_cnt;
		sw_a[b] <= 1'b0;
		repeat (8) @(posedge ref_clk_in);
		check(8'(wake_cnt - c), x);
	endtask : wake_try

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test

	// ****************************************
	// Clock, monitor, watchdog
	// ****************************************
	initial begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	always @(posedge ref_clk_in) begin
		if (rd_seen) check(reg_rdata_out, exp_q.pop_front());
		rd_seen <= reg_rd_in;
	end

	always @(negedge ref_clk_in) begin
		if (wake_req_out === 1'b1) wake_cnt++;
	end

	initial begin
		repeat (20000) @(posedge ref_clk_in);
		fails++;
		finish_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{reg_wr_in, reg_rd_in, halt_mode_in, rd_seen} = 4'h0;
		reg_addr_in = 3'h0;
		reg_wdata_in = 8'h00;
		resetn_in = 1'b0;
		pa_gpio_sel_in = 8'hFF;
		pa_nmos_in = 8'h00;
		pb_nmos_in = 8'h00;
		sw_en_b = 8'hFF;
		sw_a = 8'($urandom(32'h4C357A6B));
		sw_b = 8'($urandom());
		repeat (3) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		e = '{sw_a, 8'hFF, 8'h00, 8'h00, sw_b & 8'h3F, 8'h3F, 8'h00, 8'h00};
		check(pa_pin_oe_out, 8'h00);
		check(pa_pin_out, 8'hFF);
		for (int i = 0; i < 8; i++) rd_reg(3'(i), e[i]);
		$display("Reset value test done");
		for (int r = 0; r < 3; r++) begin
			sw_a <= 8'($urandom());
			sw_b <= 8'($urandom());
			pa_nmos_in <= 8'($urandom());
			pb_nmos_in <= 8'($urandom());
			for (int i = 0; i < 8; i++) begin
				v[i] = 8'($urandom());
				e[i] = v[i] & (i < 4 ? 8'hFF : (i < 7 ? 8'h3F : 8'h00));
				wr_reg(3'(i), v[i]);
			end
			repeat (4) @(posedge ref_clk_in);
			e[0] = (v[0] & ~v[1]) | (sw_a & v[1]);
			e[4] = ((v[4] & ~v[5]) | (sw_b & v[5])) & 8'h3F;
			for (int i = 0; i < 8; i++) rd_reg(3'(i), e[i]);
			check(pa_pin_out, v[0]);
			check(pa_pin_oe_out, ~v[1]);
			check(pa_pullup_out, v[2] & (v[1] | pa_nmos_in));
			check(pb_pullup_out, v[6] & (v[5] | pb_nmos_in) & 8'h3F);
			check(pb_pin_out, v[4] & 8'h3F);
			check(pb_pin_oe_out, ~v[5] & 8'h3F);
		end
		$display("Register and pin test done");
		wr_reg(BIO_PORT_B_DIRECTION, 8'h3F);
		wr_reg(BIO_PORT_B_PULLUP, 8'h3F);
		sw_en_b <= 8'h00;
		repeat (4) @(posedge ref_clk_in);
		rd_reg(BIO_PORT_B_DATA, 8'h3F);
		sw_en_b <= 8'hFF;
		$display("Pull-up test done");
		sw_a <= 8'hFF;
		wr_reg(BIO_PORT_A_DIRECTION, 8'hFF);
		wr_reg(BIO_PORT_A_WAKE, 8'h01);
		halt_mode_in <= 1'b1;
		wake_try(0, 8'h01);
		wake_try(1, 8'h00);
		pa_gpio_sel_in <= 8'hFE;
		wake_try(0, 8'h00);
		pa_gpio_sel_in <= 8'hFF;
		halt_mode_in <= 1'b0;
		wake_try(0, 8'h00);
		$display("Wake test done");
		resetn_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		check(pb_pin_out, 8'h3F);
		check(pb_pin_oe_out, 8'h00);
		e = '{sw_a, 8'hFF, 8'h00, 8'h00, sw_b & 8'h3F, 8'h3F, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) rd_reg(3'(i), e[i]);
		$display("Mid-run reset test done");
		repeat (3) @(posedge ref_clk_in);
		finish_test();
	end
endmodule : tb_top
